// File: hw/acf_flag_top.sv
/*
  ALU condition-flag register with a classic Wishbone slave.
  Holds the five flags, registers each ALU result and merges flag
  updates from operations, flag-register destination writes and bus
  writes.
  Assumes operations arrive as one-cycle opValid strobes synchronous to
  ref_clk and a single-cycle classic Wishbone master.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acf_map.svh"

module acf_flag_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic opValid,
  input wire acf_pkg::acf_op_t opCode,
  input wire logic [7:0] opW,
  input wire logic [7:0] opF,
  input wire logic opToFlags,
  output logic [7:0] opResult,
  output logic opDone,
  output logic [7:0] flagView
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic ack;
    logic [31:0] rdData;
    acf_pkg::acf_flags_t flags;
    logic [7:0] result;
    logic done;
  } acf_state_t;

  acf_state_t st;
  acf_state_t next_st;

  function automatic logic acfIsFlags(input logic [3:0] adr);
    acfIsFlags = (adr == `ACF_FLAGS_ADDR);
  endfunction

  function automatic logic acfIsResult(input logic [3:0] adr);
    acfIsResult = (adr == `ACF_RESULT_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // flag calculator

  acf_calc_if calcBus ();

  assign calcBus.opCode = opCode;
  assign calcBus.opW = opW;
  assign calcBus.opF = opF;
  assign calcBus.carryIn = st.flags.carry;

  acf_flag_calc u_calc (
    .calc(calcBus.calc)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-bit flag merge

  logic busReq;
  logic busWrFlags;
  logic [4:0] curFlags;
  logic [4:0] calcFlags;
  logic [4:0] mergedFlags;

  assign busReq = wb_cyc_i && wb_stb_i;
  // a write lands on the edge that completes the handshake
  assign busWrFlags = busReq && st.ack && wb_we_i && wb_sel_i[0] &&
                      acfIsFlags(wb_adr_i);
  assign curFlags = st.flags;
  assign calcFlags = calcBus.flags;

  genvar gi;
  generate
    for (gi = 0; gi < `ACF_FLAG_COUNT; gi++) begin : g_flag
      always_comb begin
        if (opValid && calcBus.affect[gi]) begin
          // the core's own flag result beats any destination write
          mergedFlags[gi] = calcFlags[gi];
        end else if (opValid && opToFlags) begin
          mergedFlags[gi] = calcBus.result[gi];
        end else if (busWrFlags) begin
          // bus loses to a same-cycle operation that affects this bit or writes the flags; software is slower
          mergedFlags[gi] = wb_dat_i[gi];
        end else begin
          mergedFlags[gi] = curFlags[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.flags = acf_pkg::acf_flags_t'(mergedFlags);
    next_st.done = opValid;
    if (opValid) begin
      next_st.result = calcBus.result;
    end
    // ack one cycle after the request, dropped right after
    next_st.ack = busReq && !st.ack;
    if (busReq && !st.ack) begin
      if (acfIsFlags(wb_adr_i)) begin
        next_st.rdData = {27'h0000000, st.flags};
      end else if (acfIsResult(wb_adr_i)) begin
        next_st.rdData = {24'h000000, st.result};
      end else begin
        next_st.rdData = 32'h00000000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st.ack <= 1'b0;
      st.rdData <= 32'h00000000;
      st.flags <= acf_pkg::acf_flags_t'(`ACF_FLAGS_RESET);
      st.result <= `ACF_RESULT_RESET;
      st.done <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdData;
  assign opResult = st.result;
  assign opDone = st.done;
  assign flagView = {3'h0, st.flags};

endmodule

`default_nettype wire

// File: common/acf_map.svh
/*
  Offsets, field positions, reset values and flag-effect masks of the
  ALU condition-flag block.
  Assumes a 4-bit Wishbone byte address and 32-bit data words.
*/
// Operation
// - flag register bits 7 to 5 are unimplemented and read zero.
// - negative flag copies the most significant result bit.
// - overflow flag set when signed arithmetic flips the sign wrongly.
// - zero flag set when the operation result equals zero.
// - add and subtract set nibble carry on carry out of bit 3.
// - rotates load nibble carry from source bit 4 or 3 by direction.
// - add and subtract set carry on carry out of bit 7.
// - subtract adds two's complement, so carries mean no borrow.
// - rotate through carry loads carry from source high or low bit.
// - computed flags beat a write of the flag register by that operation.
// - pointer increment or decrement alters no flag unless opToFlags writes its result to the flag register.
`ifndef ACF_MAP_SVH
`define ACF_MAP_SVH

`define ACF_FLAGS_ADDR 4'h0
`define ACF_RESULT_ADDR 4'h4

`define ACF_NEG_BIT 4
`define ACF_OVF_BIT 3
`define ACF_ZERO_BIT 2
`define ACF_NIB_BIT 1
`define ACF_CARRY_BIT 0
`define ACF_FLAG_COUNT 5

`define ACF_FLAGS_RESET 5'h00
`define ACF_RESULT_RESET 8'h00

`define ACF_AFFECT_ARITH 5'h1F
`define ACF_AFFECT_LOGIC 5'h14
`define ACF_AFFECT_ROT_C 5'h17
`define ACF_AFFECT_ROT_N 5'h16
`define ACF_AFFECT_NONE 5'h00

`endif

// File: common/acf_pkg.sv
/*
  Types of the ALU condition-flag block: operation codes and flag layout.
  Assumes acf_map.svh for the numeric constants.
*/
`default_nettype none

package acf_pkg;

  typedef enum logic [3:0] {
    ACF_OP_ADD,
    ACF_OP_SUB,
    ACF_OP_AND,
    ACF_OP_IOR,
    ACF_OP_XOR,
    ACF_OP_MOVF,
    ACF_OP_RRC,
    ACF_OP_RLC,
    ACF_OP_RRNC,
    ACF_OP_RLNC,
    ACF_OP_PTR_INC,
    ACF_OP_PTR_DEC,
    ACF_OP_PASS
  } acf_op_t;

  // bit order matches the flag register, negative at bit 4
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic nib;
    logic carry;
  } acf_flags_t;

endpackage

`default_nettype wire

// File: common/acf_calc_if.sv
/*
  Interface between the flag register top and the flag calculator.
  Assumes both ends run in one combinational path, no clock inside.
*/
`timescale 1ns/1ps
`default_nettype none

interface acf_calc_if;
  acf_pkg::acf_op_t opCode;
  logic [7:0] opW;
  logic [7:0] opF;
  logic carryIn;
  logic [7:0] result;
  acf_pkg::acf_flags_t flags;
  logic [4:0] affect;

  modport calc (
    input opCode, opW, opF, carryIn,
    output result, flags, affect
  );
  modport user (
    output opCode, opW, opF, carryIn,
    input result, flags, affect
  );
endinterface

`default_nettype wire

// File: hw/acf_flag_calc.sv
/*
  Combinational ALU result and condition-flag calculator.
  Assumes the caller registers result and flags; carryIn is the stored
  carry flag.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acf_map.svh"

module acf_flag_calc (
  acf_calc_if.calc calc
);

  logic sub;
  logic [7:0] addend;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] res;
  logic ovf;

  always_comb begin
    // subtract is f plus the two's complement of w
    sub = (calc.opCode == acf_pkg::ACF_OP_SUB);
    addend = sub ? ~calc.opW : calc.opW;
    sum9 = {1'b0, calc.opF} + {1'b0, addend} + {8'h00, sub};
    nib5 = {1'b0, calc.opF[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
    ovf = (calc.opF[7] == addend[7]) && (sum9[7] != calc.opF[7]);
    res = calc.opF;
    calc.affect = `ACF_AFFECT_NONE;
    calc.flags.ovf = ovf;
    calc.flags.nib = nib5[4];
    calc.flags.carry = sum9[8];
    unique case (calc.opCode)
      acf_pkg::ACF_OP_ADD, acf_pkg::ACF_OP_SUB: begin
        res = sum9[7:0];
        calc.affect = `ACF_AFFECT_ARITH;
      end
      acf_pkg::ACF_OP_AND: begin
        res = calc.opW & calc.opF;
        calc.affect = `ACF_AFFECT_LOGIC;
      end
      acf_pkg::ACF_OP_IOR: begin
        res = calc.opW | calc.opF;
        calc.affect = `ACF_AFFECT_LOGIC;
      end
      acf_pkg::ACF_OP_XOR: begin
        res = calc.opW ^ calc.opF;
        calc.affect = `ACF_AFFECT_LOGIC;
      end
      acf_pkg::ACF_OP_MOVF: begin
        calc.affect = `ACF_AFFECT_LOGIC;
      end
      acf_pkg::ACF_OP_RRC: begin
        res = {calc.carryIn, calc.opF[7:1]};
        calc.flags.carry = calc.opF[0];
        calc.flags.nib = calc.opF[4];
        calc.affect = `ACF_AFFECT_ROT_C;
      end
      acf_pkg::ACF_OP_RLC: begin
        res = {calc.opF[6:0], calc.carryIn};
        calc.flags.carry = calc.opF[7];
        calc.flags.nib = calc.opF[3];
        calc.affect = `ACF_AFFECT_ROT_C;
      end
      acf_pkg::ACF_OP_RRNC: begin
        res = {calc.opF[0], calc.opF[7:1]};
        calc.flags.nib = calc.opF[4];
        calc.affect = `ACF_AFFECT_ROT_N;
      end
      acf_pkg::ACF_OP_RLNC: begin
        res = {calc.opF[6:0], calc.opF[7]};
        calc.flags.nib = calc.opF[3];
        calc.affect = `ACF_AFFECT_ROT_N;
      end
      // pointer stepping leaves every flag alone, even at zero
      acf_pkg::ACF_OP_PTR_INC: begin
        res = calc.opF + 8'h01;
      end
      acf_pkg::ACF_OP_PTR_DEC: begin
        res = calc.opF - 8'h01;
      end
      acf_pkg::ACF_OP_PASS: begin
        res = calc.opW;
      end
      default: begin
        res = calc.opF;
      end
    endcase
    calc.result = res;
    calc.flags.neg = res[7];
    calc.flags.zero = (res == 8'h00);
  end

endmodule

`default_nettype wire

// File: testbench/acf_flag_chk.sv
/*
  Port checker of the flag block, bound to acf_flag_top.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module acf_flag_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic opValid,
  input wire acf_pkg::acf_op_t opCode,
  input wire logic [7:0] opW,
  input wire logic [7:0] opF,
  input wire logic opToFlags,
  input wire logic [7:0] opResult,
  input wire logic opDone,
  input wire logic [7:0] flagView
);
  logic [8:0] addS;
  logic [8:0] subS;
  logic [4:0] addN;
  logic ovfA;
  logic busW;
  logic keep;
  assign addS = {1'h0, opF} + {1'h0, opW};
  assign subS = {1'h0, opF} + {1'h0, ~opW} + 9'h001;
  assign addN = {1'h0, opF[3:0]} + {1'h0, opW[3:0]};
  assign ovfA = (opF[7] == opW[7]) && (addS[7] != opF[7]);
  // a bus write in the same cycle may legally change unaffected flags
  assign busW = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
  assign keep = opValid & ~opToFlags & ~busW;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////
  upper_zero_a: assert property (flagView[7:5] == 3'h0)
    else $error("flag bits 7 to 5 not zero");
  neg_copy_a: assert property (
    opValid && opCode < acf_pkg::ACF_OP_PTR_INC |=>
    flagView[4] == opResult[7]) else $error("negative flag wrong");
  zero_set_a: assert property (
    opValid && opCode < acf_pkg::ACF_OP_PTR_INC |=>
    flagView[2] == (opResult == 8'h00)) else $error("zero flag wrong");
  add_carry_a: assert property (
    opValid && opCode == acf_pkg::ACF_OP_ADD |=>
    flagView[0] == $past(addS[8]) && flagView[1] == $past(addN[4]))
    else $error("add carries wrong");
  add_ovf_a: assert property (
    opValid && opCode == acf_pkg::ACF_OP_ADD |=>
    flagView[3] == $past(ovfA)) else $error("overflow wrong");
  sub_borrow_a: assert property (
    opValid && opCode == acf_pkg::ACF_OP_SUB |=>
    flagView[0] == $past(subS[8])) else $error("borrow wrong");
  rot_carry_a: assert property (
    opValid && opCode == acf_pkg::ACF_OP_RRC |=>
    flagView[0] == $past(opF[0]) && flagView[1] == $past(opF[4]))
    else $error("rotate carries wrong");
  ptr_hold_a: assert property (
    keep && opCode == acf_pkg::ACF_OP_PTR_INC |=> $stable(flagView))
    else $error("pointer op changed flags");
  rot_keep_a: assert property (
    keep && opCode == acf_pkg::ACF_OP_RRNC |=>
    flagView[0] == $past(flagView[0])) else $error("carry not kept");
  op_done_a: assert property (opValid |=> opDone)
    else $error("no done pulse");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  cover property (opValid && opCode == acf_pkg::ACF_OP_ADD && addS[8]);
  cover property (busW);
  cover property (opValid && opToFlags);
endmodule

bind acf_flag_top acf_flag_chk chk (.ref_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_ack_o, .opValid, .opCode, .opW, .opF,
  .opToFlags, .opResult, .opDone, .flagView);

`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench of the flag block against a reference model.
  Assumes the single-cycle Wishbone timing of the block's hand-over.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acf_map.svh"

module tb_top;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic opValid = 1'h0;
  acf_pkg::acf_op_t opCode = acf_pkg::ACF_OP_PASS;
  logic [7:0] opW = 8'h00;
  logic [7:0] opF = 8'h00;
  logic opToFlags = 1'h0;
  logic [7:0] opResult;
  logic opDone;
  logic [7:0] flagView;
  logic [4:0] mf = 5'h00;
  logic [7:0] lastR = 8'h00;
  logic [12:0] expQ[$];
  logic [12:0] expOp;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  acf_flag_top DUT (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .opValid,
    .opCode, .opW, .opF, .opToFlags, .opResult, .opDone, .flagView);

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // op results are settled mid-cycle, while opDone stands
  always @(negedge ref_clk) begin
    if (opDone === 1'h1) begin
      expOp = (expQ.size() > 0) ? expQ.pop_front() : 13'h1FFF;
      chk("result", 32'(expOp[7:0]), 32'(opResult));
      chk("flags", 32'(expOp[12:8]), 32'(flagView));
    end
  end

  task automatic wb(logic we, logic [3:0] a, logic [3:0] s, logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (we && a == `ACF_FLAGS_ADDR && s[0]) mf = d[4:0];
    @(posedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  // packs {affected mask, flag values, result}
  function automatic logic [17:0] model(acf_pkg::acf_op_t c,
                                        logic [7:0] w, logic [7:0] f);
    logic [8:0] s;
    logic [7:0] v;
    logic [7:0] r;
    logic [4:0] l;
    logic [4:0] a;
    logic b;
    b = c == acf_pkg::ACF_OP_SUB;
    v = b ? ~w : w;
    s = {1'h0, f} + {1'h0, v} + 9'(b);
    l = {1'h0, (f[7] == v[7]) && (s[7] != f[7]), 1'h0,
         5'(f[3:0]) + 5'(v[3:0]) + 5'(b) > 5'h0F, s[8]};
    r = s[7:0];
    a = `ACF_AFFECT_LOGIC;
    case (c)
      acf_pkg::ACF_OP_AND: r = w & f;
      acf_pkg::ACF_OP_IOR: r = w | f;
      acf_pkg::ACF_OP_XOR: r = w ^ f;
      acf_pkg::ACF_OP_MOVF: r = f;
      acf_pkg::ACF_OP_RRC: r = {mf[0], f[7:1]};
      acf_pkg::ACF_OP_RLC: r = {f[6:0], mf[0]};
      acf_pkg::ACF_OP_RRNC: r = {f[0], f[7:1]};
      acf_pkg::ACF_OP_RLNC: r = {f[6:0], f[7]};
      acf_pkg::ACF_OP_PTR_INC: r = f + 8'h01;
      acf_pkg::ACF_OP_PTR_DEC: r = f - 8'h01;
      acf_pkg::ACF_OP_PASS: r = w;
      acf_pkg::ACF_OP_ADD, acf_pkg::ACF_OP_SUB: a = `ACF_AFFECT_ARITH;
      default: r = f;
    endcase
    if (c >= acf_pkg::ACF_OP_RRC) begin
      l[1] = c[0] ? f[3] : f[4];
      l[0] = c[0] ? f[7] : f[0];
      a = c < acf_pkg::ACF_OP_RRNC ? `ACF_AFFECT_ROT_C : `ACF_AFFECT_ROT_N;
    end
    if (c >= acf_pkg::ACF_OP_PTR_INC) a = `ACF_AFFECT_NONE;
    l[4] = r[7];
    l[2] = r == 8'h00;
    return {a, l, r};
  endfunction

  task automatic op(acf_pkg::acf_op_t c, logic [7:0] w, logic [7:0] f,
                    logic t);
    logic [17:0] m;
    logic [4:0] n;
    opValid <= 1'h1;
    opCode <= c;
    opW <= w;
    opF <= f;
    opToFlags <= t;
    m = model(c, w, f);
    @(posedge ref_clk);
    n = t ? m[4:0] : mf;
    mf = (n & ~m[17:13]) | (m[12:8] & m[17:13]);
    lastR = m[7:0];
    // opValid stays up so ops can run back to back; the caller drops it
    expQ.push_back({mf, lastR});
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    void'($urandom(32'h58BB200D));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'h1;
    wb(1'h0, `ACF_FLAGS_ADDR, 4'hF, 32'h0, q);
    chk("reset", 32'h0, q);
    wb(1'h1, `ACF_FLAGS_ADDR, 4'h1, 32'hFFFFFFFF, q);
    wb(1'h1, `ACF_FLAGS_ADDR, 4'h0, 32'h0, q);
    wb(1'h0, `ACF_FLAGS_ADDR, 4'h1, 32'h0, q);
    chk("flagreg", 32'h1F, q);
    op(acf_pkg::ACF_OP_PTR_INC, 8'h00, 8'hFF, 1'h0);
    op(acf_pkg::ACF_OP_ADD, 8'h01, 8'h7F, 1'h1);
    op(acf_pkg::ACF_OP_SUB, 8'h01, 8'h10, 1'h0);
    op(acf_pkg::ACF_OP_RRNC, 8'h00, 8'h11, 1'h0);
    op(acf_pkg::ACF_OP_RLC, 8'h00, 8'h88, 1'h0);
    opValid <= 1'h0;
    wb(1'h1, `ACF_RESULT_ADDR, 4'h1, 32'h55, q);
    wb(1'h0, `ACF_RESULT_ADDR, 4'h1, 32'h0, q);
    chk("resreg", 32'(lastR), q);
    wb(1'h0, 4'h8, 4'h1, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // back-to-back random traffic over every code, illegal ones too
    repeat (300) begin
      op(acf_pkg::acf_op_t'($urandom_range(15)), 8'($urandom),
         8'($urandom), 1'($urandom));
    end
    opValid <= 1'h0;
    repeat (2) @(posedge ref_clk);
    chk("pending", 32'h0, 32'(expQ.size()));
    finish_test();
  end
endmodule

`default_nettype wire
